// [pefc_top.sv]
// Overview of operation
// - External reset input is active low; low holds all but the parameter RAM reset.
// - Data line is bidirectional; each side drives only in its own phase.
// - Parameters go into on-chip RAM or registers, then a service call runs.
// - Writing the request bit enters privileged mode and starts the service.
// - Argument register holds one argument or a pointer to an argument array.
// - Writing the mode bit of the programming-entry register enters programming mode.
`timescale 1ns/100ps
`default_nettype none
module pefc_top #(
  parameter logic [31:0] LINK_ID_CODE = 32'h1234_5677  // Arbitrary value
) (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        swd_clk_in,
  input  wire logic        swdio_in,
  output logic             swdio_out,
  output logic             swdio_oe_out,
  output logic             privileged_out,
  output logic             service_start_out,
  output logic [31:0]      service_request_out,
  output logic [31:0]      service_argument_out,
  input  wire logic        service_done_in,
  input  wire logic [31:0] service_status_in,
  output logic             prog_mode_out,
  input  wire logic [3:0]  param_addr_in,
  output logic [31:0]      param_data_out
);

  function automatic logic is_param(input logic [31:0] a);
    return a[31:6] == pefc_pkg::REQUEST_PARAM_BASE[31:6];
  endfunction

  // ---------------- Link domain ----------------
  logic [1:0]                    link_rst_q;
  logic                          link_rst_n;
  pefc_pkg::pefc_link_state_type state_q, state_d;
  logic [5:0]                    cnt_q, cnt_d;
  logic [5:0]                    ones_q, ones_d;
  logic [7:0]                    req_q, req_d;
  logic [34:0]                   sr_q, sr_d;
  logic                          oe_q, oe_d;
  logic                          out_q, out_d;
  logic [2:0]                    ack_q, ack_d;
  logic [32:0]                   wdata_q, wdata_d;
  logic [31:0]                   ctrl_q, ctrl_d;
  logic [31:0]                   csw_q, csw_d;
  logic [31:0]                   tar_q, tar_d;
  logic [31:0]                   select_q, select_d;
  pefc_pkg::pefc_mem_req_type    preq_q, preq_d;
  logic                          req_tgl_q, req_tgl_d;
  logic                          ack_s1_q, ack_s2_q;
  logic [31:0]                   core_rdata_q;
  logic                          ack_tgl_q;

  logic        ap, rnw, hdr_ok, busy, needs_core;
  logic [1:0]  rsel;
  logic [31:0] rdata;
  logic [32:0] wfull;

  // Reset reaches the link logic asynchronously, leaves it on its own clock
  always_ff @(posedge swd_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_rst_q <= 2'b00;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_q[1];

  assign ap         = req_q[1];
  assign rnw        = req_q[2];
  assign rsel       = req_q[4:3];
  assign hdr_ok     = req_q[0] && !req_q[6] && req_q[7] &&
                      ((^req_q[4:1]) == req_q[5]);
  assign busy       = req_tgl_q != ack_s2_q;
  assign needs_core = (rsel == pefc_pkg::AP_DRW) && (ap || rnw);
  assign wfull      = {swdio_in, wdata_q[32:1]};

  always_comb begin
    case ({ap, rsel})
      {1'b0, pefc_pkg::DP_ID_ABORT}:  rdata = LINK_ID_CODE;
      {1'b0, pefc_pkg::DP_CTRL_STAT}: rdata = ctrl_q;
      {1'b1, pefc_pkg::AP_CSW}:       rdata = csw_q;
      {1'b1, pefc_pkg::AP_TAR}:       rdata = tar_q;
      {1'b0, pefc_pkg::DP_RDBUFF},
      {1'b1, pefc_pkg::AP_DRW}:       rdata = core_rdata_q;
      default:                        rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    req_d     = req_q;
    sr_d      = sr_q;
    oe_d      = oe_q;
    out_d     = out_q;
    ack_d     = ack_q;
    wdata_d   = wdata_q;
    ctrl_d    = ctrl_q;
    csw_d     = csw_q;
    tar_d     = tar_q;
    select_d  = select_q;
    preq_d    = preq_q;
    req_tgl_d = req_tgl_q;
    ones_d    = swdio_in ? ((ones_q == 6'h3f) ? ones_q : ones_q + 6'h01)
                         : 6'h00;
    case (state_q)
      pefc_pkg::LS_IDLE: begin
        if (swdio_in) begin
          req_d   = {swdio_in, req_q[7:1]};
          cnt_d   = 6'h01;
          state_d = pefc_pkg::LS_REQ;
        end
      end
      pefc_pkg::LS_REQ: begin
        req_d = {swdio_in, req_q[7:1]};
        cnt_d = cnt_q + 6'h01;
        if (cnt_q == 6'h07) begin
          state_d = pefc_pkg::LS_TRN_IN;
        end
      end
      pefc_pkg::LS_TRN_IN: begin
        // A malformed header gets no answer; the line stays released
        if (!hdr_ok) begin
          state_d = pefc_pkg::LS_IDLE;
        end else begin
          if (ap && ctrl_q[pefc_pkg::WDATAERR_POS]) begin
            ack_d = pefc_pkg::ACK_FAULT;
          end else if (needs_core && busy) begin
            ack_d = pefc_pkg::ACK_WAIT;
          end else begin
            ack_d = pefc_pkg::ACK_OK;
          end
          oe_d    = 1'b1;
          out_d   = ack_d[0];
          state_d = pefc_pkg::LS_DRIVE;
          cnt_d   = 6'h02;
          sr_d    = {32'h0000_0000, 1'b0, ack_d[2:1]};
          if (rnw && ack_d == pefc_pkg::ACK_OK) begin
            sr_d  = {^rdata, rdata, ack_d[2:1]};
            cnt_d = 6'h23;
            // AP_DRW reads are posted: this answer carries the previous result
            if (ap && rsel == pefc_pkg::AP_DRW) begin
              preq_d    = '{write: 1'b0, addr: tar_q, data: 32'h0000_0000};
              req_tgl_d = !req_tgl_q;
            end
          end
        end
      end
      pefc_pkg::LS_DRIVE: begin
        if (cnt_q != 6'h00) begin
          out_d = sr_q[0];
          sr_d  = {1'b0, sr_q[34:1]};
          cnt_d = cnt_q - 6'h01;
        end else begin
          oe_d    = 1'b0;
          out_d   = 1'b0;
          cnt_d   = 6'h00;
          state_d = (!rnw && ack_q == pefc_pkg::ACK_OK) ?
                    pefc_pkg::LS_WDATA : pefc_pkg::LS_IDLE;
        end
      end
      pefc_pkg::LS_WDATA: begin
        wdata_d = wfull;
        cnt_d   = cnt_q + 6'h01;
        if (cnt_q == 6'h20) begin
          state_d = pefc_pkg::LS_IDLE;
          if ((^wfull[31:0]) != wfull[32]) begin
            ctrl_d[pefc_pkg::WDATAERR_POS] = 1'b1;
          end else begin
            case ({ap, rsel})
              {1'b0, pefc_pkg::DP_ID_ABORT}: begin
                if (wfull[pefc_pkg::WDERRCLR_POS]) begin
                  ctrl_d[pefc_pkg::WDATAERR_POS] = 1'b0;
                end
              end
              {1'b0, pefc_pkg::DP_CTRL_STAT}: begin
                ctrl_d = wfull[31:0];
                ctrl_d[pefc_pkg::WDATAERR_POS] =
                  ctrl_q[pefc_pkg::WDATAERR_POS];
              end
              {1'b0, pefc_pkg::DP_SELECT}: select_d = wfull[31:0];
              {1'b1, pefc_pkg::AP_CSW}:    csw_d    = wfull[31:0];
              {1'b1, pefc_pkg::AP_TAR}:    tar_d    = wfull[31:0];
              {1'b1, pefc_pkg::AP_DRW}: begin
                preq_d    = '{write: 1'b1, addr: tar_q, data: wfull[31:0]};
                req_tgl_d = !req_tgl_q;
              end
              default: ;
            endcase
          end
        end
      end
      default: begin
        // Link reset state: nothing is answered until the line is reset
        oe_d = 1'b0;
      end
    endcase
    // Line reset overrides any phase; a partial frame is dropped
    if (ones_q >= pefc_pkg::LINE_RESET_ONES && !swdio_in) begin
      state_d = pefc_pkg::LS_IDLE;
      oe_d    = 1'b0;
      out_d   = 1'b0;
    end
  end

  always_ff @(posedge swd_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_q   <= pefc_pkg::LS_RESET;
      cnt_q     <= 6'h00;
      ones_q    <= 6'h00;
      req_q     <= 8'h00;
      sr_q      <= 35'h0_0000_0000;
      oe_q      <= 1'b0;
      out_q     <= 1'b0;
      ack_q     <= 3'h0;
      wdata_q   <= 33'h0_0000_0000;
      ctrl_q    <= pefc_pkg::CTRL_STAT_RST;
      csw_q     <= pefc_pkg::CSW_RST;
      tar_q     <= 32'h0000_0000;
      select_q  <= 32'h0000_0000;
      preq_q    <= '0;
      req_tgl_q <= 1'b0;
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      ones_q    <= ones_d;
      req_q     <= req_d;
      sr_q      <= sr_d;
      oe_q      <= oe_d;
      out_q     <= out_d;
      ack_q     <= ack_d;
      wdata_q   <= wdata_d;
      ctrl_q    <= ctrl_d;
      csw_q     <= csw_d;
      tar_q     <= tar_d;
      select_q  <= select_d;
      preq_q    <= preq_d;
      req_tgl_q <= req_tgl_d;
      ack_s1_q  <= ack_tgl_q;
      ack_s2_q  <= ack_s1_q;
    end
  end

  assign swdio_out    = out_q;
  assign swdio_oe_out = oe_q;

  a_idle_released: assert property (@(posedge swd_clk_in)
    disable iff (!link_rst_n)
    (state_q == pefc_pkg::LS_IDLE || state_q == pefc_pkg::LS_WDATA)
      |-> !swdio_oe_out)
    else $error("Data line driven outside the answer phase");

  a_ack_drives: assert property (@(posedge swd_clk_in)
    disable iff (!link_rst_n)
    (state_q == pefc_pkg::LS_TRN_IN && hdr_ok)
      |=> swdio_oe_out ##1 swdio_oe_out ##1 swdio_oe_out)
    else $error("Acknowledge not driven for three link clocks");

  // ---------------- Core domain ----------------
  logic        rq_s1_q, rq_s2_q, rq_s3_q;
  logic        new_req;
  logic        ack_tgl_d;
  logic [31:0] core_rdata_d;
  logic [31:0] sysreq_q, sysreq_d;
  logic [31:0] sysarg_q, sysarg_d;
  logic [31:0] prog_q, prog_d;
  logic        priv_q, priv_d;
  logic        start_q, start_d;
  logic [31:0] param_ram_q [pefc_pkg::PARAM_WORDS];
  logic [31:0] param_data_q;
  logic        wr_sysreq, wr_sysarg, wr_prog, wr_param;

  assign new_req   = rq_s2_q ^ rq_s3_q;
  assign wr_sysreq = new_req && preq_q.write &&
                     preq_q.addr == pefc_pkg::SYSTEM_REQUEST_ADDR;
  assign wr_sysarg = new_req && preq_q.write &&
                     preq_q.addr == pefc_pkg::SYSTEM_ARGUMENT_ADDR;
  assign wr_prog   = new_req && preq_q.write &&
                     preq_q.addr == pefc_pkg::PROG_ENTRY_ADDR;
  assign wr_param  = new_req && preq_q.write && is_param(preq_q.addr);

  always_comb begin
    sysreq_d     = sysreq_q;
    sysarg_d     = sysarg_q;
    prog_d       = prog_q;
    priv_d       = priv_q;
    start_d      = 1'b0;
    core_rdata_d = core_rdata_q;
    ack_tgl_d    = ack_tgl_q ^ new_req;
    // Completion first, so a request written in the same cycle wins
    if (service_done_in) begin
      sysarg_d = service_status_in;
      sysreq_d = sysreq_q & ~(pefc_pkg::SYSREQ_BIT |
                              pefc_pkg::PRIVILEGED_BIT);
      priv_d   = 1'b0;
    end
    if (wr_sysreq) begin
      sysreq_d = preq_q.data;
      if ((preq_q.data & pefc_pkg::SYSREQ_BIT) != 32'h0000_0000) begin
        priv_d  = 1'b1;
        start_d = 1'b1;
      end
    end
    if (wr_sysarg) begin
      sysarg_d = preq_q.data;
    end
    if (wr_prog) begin
      prog_d = preq_q.data;
    end
    if (new_req && !preq_q.write) begin
      if (preq_q.addr == pefc_pkg::SYSTEM_REQUEST_ADDR) begin
        core_rdata_d = sysreq_q |
                       (priv_q ? pefc_pkg::PRIVILEGED_BIT : 32'h0000_0000);
      end else if (preq_q.addr == pefc_pkg::SYSTEM_ARGUMENT_ADDR) begin
        core_rdata_d = sysarg_q;
      end else if (preq_q.addr == pefc_pkg::PROG_ENTRY_ADDR) begin
        core_rdata_d = prog_q;
      end else if (is_param(preq_q.addr)) begin
        core_rdata_d = param_ram_q[preq_q.addr[5:2]];
      end else begin
        core_rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rq_s1_q      <= 1'b0;
      rq_s2_q      <= 1'b0;
      rq_s3_q      <= 1'b0;
      ack_tgl_q    <= 1'b0;
      core_rdata_q <= 32'h0000_0000;
      sysreq_q     <= pefc_pkg::SYSREQ_RST;
      sysarg_q     <= pefc_pkg::SYSARG_RST;
      prog_q       <= pefc_pkg::PROG_ENTRY_RST;
      priv_q       <= 1'b0;
      start_q      <= 1'b0;
    end else begin
      rq_s1_q      <= req_tgl_q;
      rq_s2_q      <= rq_s1_q;
      rq_s3_q      <= rq_s2_q;
      ack_tgl_q    <= ack_tgl_d;
      core_rdata_q <= core_rdata_d;
      sysreq_q     <= sysreq_d;
      sysarg_q     <= sysarg_d;
      prog_q       <= prog_d;
      priv_q       <= priv_d;
      start_q      <= start_d;
    end
  end

  // Parameter RAM has no reset; the service reads it through its own port
  always_ff @(posedge ref_clk_in) begin
    if (wr_param) begin
      param_ram_q[preq_q.addr[5:2]] <= preq_q.data;
    end
    param_data_q <= param_ram_q[param_addr_in];
  end

  assign privileged_out       = priv_q;
  assign service_start_out    = start_q;
  assign service_request_out  = sysreq_q;
  assign service_argument_out = sysarg_q;
  assign prog_mode_out        = (prog_q & pefc_pkg::PROG_MODE_BIT) != '0;
  assign param_data_out       = param_data_q;

  a_reset_clears: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    $rose(reset_n_in) |-> !privileged_out && !prog_mode_out &&
                          !service_start_out)
    else $error("State not cleared by external reset");

  a_req_enters_priv: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    wr_sysreq && (preq_q.data & pefc_pkg::SYSREQ_BIT) != '0
      |=> privileged_out && service_start_out ##1 !service_start_out)
    else $error("Request write did not enter privileged mode");

  a_done_leaves_priv: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    service_done_in && !wr_sysreq |=> !privileged_out)
    else $error("Privileged mode held after service completion");

  a_arg_written: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    wr_sysarg && !service_done_in
      |=> service_argument_out == $past(preq_q.data))
    else $error("Argument register missed a write");

  a_arg_holds: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    !wr_sysarg && !service_done_in |=> $stable(service_argument_out))
    else $error("Argument register changed without cause");

  a_prog_entry: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    wr_prog && (preq_q.data & pefc_pkg::PROG_MODE_BIT) != '0
      |=> prog_mode_out)
    else $error("Programming mode not entered");

  a_param_stored: assert property (@(posedge ref_clk_in)
    disable iff (!reset_n_in)
    wr_param |=> param_ram_q[$past(preq_q.addr[5:2])] == $past(preq_q.data))
    else $error("Parameter word not stored");

endmodule // pefc_top
`default_nettype wire

// [pefc_pkg.sv]
`default_nettype none
package pefc_pkg;

  // Wire answers sent in the three acknowledge bits, bit 0 first
  localparam logic [2:0] ACK_OK    = 3'h1;
  localparam logic [2:0] ACK_WAIT  = 3'h2;
  localparam logic [2:0] ACK_FAULT = 3'h4;

  // Link reset: this many high data bits, then one low bit
  localparam logic [5:0] LINE_RESET_ONES = 6'h32;

  // Debug-port register selects
  localparam logic [1:0] DP_ID_ABORT  = 2'h0;
  localparam logic [1:0] DP_CTRL_STAT = 2'h1;
  localparam logic [1:0] DP_SELECT    = 2'h2;
  localparam logic [1:0] DP_RDBUFF    = 2'h3;
  // Access-port register selects
  localparam logic [1:0] AP_CSW       = 2'h0;
  localparam logic [1:0] AP_TAR       = 2'h1;
  localparam logic [1:0] AP_DRW       = 2'h3;

  localparam logic [31:0] CTRL_STAT_RST = 32'h0000_0000;
  localparam logic [31:0] CSW_RST       = 32'h0000_0002;
  localparam int          WDATAERR_POS  = 7;
  localparam int          WDERRCLR_POS  = 3;

  // Memory-mapped words seen through the transfer-address path
  localparam logic [31:0] SYSTEM_REQUEST_ADDR  = 32'h4000_0004;
  localparam logic [31:0] SYSTEM_ARGUMENT_ADDR = 32'h4000_0008;
  localparam logic [31:0] PROG_ENTRY_ADDR      = 32'h4000_0014;
  localparam logic [31:0] REQUEST_PARAM_BASE   = 32'h2000_0100;
  localparam int          PARAM_WORDS          = 16;

  localparam logic [31:0] SYSREQ_BIT        = 32'h0800_0000;
  localparam logic [31:0] PRIVILEGED_BIT    = 32'h0100_0000;
  localparam logic [31:0] STATUS_SUCCEEDED  = 32'ha000_0000;
  localparam logic [31:0] PROG_MODE_BIT     = 32'h8000_0000;
  localparam logic [31:0] SYSREQ_RST        = 32'h0000_0000;
  localparam logic [31:0] SYSARG_RST        = 32'h0000_0000;
  localparam logic [31:0] PROG_ENTRY_RST    = 32'h0000_0000;

  // Link clock range that the programmer must keep to
  localparam int SWD_CLK_MIN_KHZ = 1500;
  localparam int SWD_CLK_MAX_KHZ = 14000;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } pefc_mem_req_type;

  typedef enum {
    LS_RESET,
    LS_IDLE,
    LS_REQ,
    LS_TRN_IN,
    LS_DRIVE,
    LS_WDATA
  } pefc_link_state_type;

endpackage
`default_nettype wire

// [pefc_swd_host.sv]
`timescale 1ns/100ps
`default_nettype none
module pefc_swd_host (
  output logic      swd_clk_out,
  output logic      drive_out,
  output logic      drive_oe_out,
  input  wire logic line_in
);
  initial begin
    swd_clk_out = 1'b0;
    drive_out = 1'b0;
    drive_oe_out = 1'b0;
  end

  // Clock stands low between frames; data changes right after the fall
  // Period 30 ns, above the field range, to keep bench runs short
  task automatic tick(input logic oe, input logic d, output logic s);
    drive_oe_out = oe;
    drive_out = d;
    #15 swd_clk_out = 1'b1;
    #14 s = line_in;
    #1 swd_clk_out = 1'b0;
  endtask

  // Idle ticks keep the link clock running so posted core work lands
  task automatic idle(input int n);
    logic s;
    for (int i = 0; i < n; i++) tick(1'b1, 1'b0, s);
  endtask

  task automatic line_reset();
    logic s;
    for (int i = 0; i < 52; i++) tick(1'b1, 1'b1, s);
    idle(2);
  endtask

  // flt[0] spoils the header parity, flt[1] the write-data parity
  task automatic xfer(input logic ap, input logic rd, input logic [1:0] a,
      input logic [31:0] wd, input logic [1:0] flt, output logic [2:0] ack,
      output logic [31:0] dat, output logic par_ok);
    logic [7:0] hdr;
    logic       s;
    hdr = {2'b10, ^{ap, rd, a} ^ flt[0], a[1], a[0], rd, ap, 1'b1};
    dat = 32'h0;
    par_ok = 1'b0;
    for (int i = 0; i < 8; i++) tick(1'b1, hdr[i], s);
    for (int i = 0; i < 3; i++) begin
      tick(1'b0, 1'b0, s);
      ack[i] = s;
    end
    if (rd && ack === 3'h1) begin
      for (int i = 0; i < 32; i++) begin
        tick(1'b0, 1'b0, s);
        dat[i] = s;
      end
      tick(1'b0, 1'b0, s);
      par_ok = (s === ^dat);
    end
    tick(1'b0, 1'b0, s);
    if (!rd && ack === 3'h1) begin
      for (int i = 0; i < 33; i++) begin
        tick(1'b1, i < 32 ? wd[i] : ^wd ^ flt[1], s);
      end
    end
    idle(8);
  endtask
endmodule // pefc_swd_host
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [31:0] ID = 32'h1234_5677; // Arbitrary value
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in;
  logic        done = 1'b0;
  logic [31:0] status = 32'h0;
  logic [3:0]  paddr = 4'h0;
  wire logic   sclk, dev_d, dev_oe, h_d, h_oe, priv, start, pmode;
  wire logic [31:0] req, arg, pdata;
  // Pull-up on the data line; contention shows as unknown
  wire logic   swdio = (dev_oe && h_oe) ? 1'bx : dev_oe ? dev_d :
                       h_oe ? h_d : 1'b1;
  int          err_count = 0;
  int          num_checks = 0;
  int          cnt = 0;
  logic [31:0] exp_status = 32'h0;
  logic [31:0] exp_req = 32'h0;
  logic [31:0] mdl [logic [31:0]];

  always #25 ref_clk_in = ~ref_clk_in;

  pefc_top #(.LINK_ID_CODE(ID)) uut (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .swd_clk_in(sclk), .swdio_in(swdio),
    .swdio_out(dev_d), .swdio_oe_out(dev_oe), .privileged_out(priv),
    .service_start_out(start), .service_request_out(req),
    .service_argument_out(arg), .service_done_in(done),
    .service_status_in(status), .prog_mode_out(pmode),
    .param_addr_in(paddr), .param_data_out(pdata));

  pefc_swd_host host (.swd_clk_out(sclk), .drive_out(h_d),
    .drive_oe_out(h_oe), .line_in(swdio));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Boot service stand-in: answers a start pulse after 300 cycles
  always @(posedge ref_clk_in) begin
    done <= 1'b0;
    if (start === 1'b1) begin
      check(req, exp_req);
      check({31'h0, priv}, 32'h1);
      cnt <= 300;
    end else if (cnt == 1) begin
      exp_status = pefc_pkg::STATUS_SUCCEEDED | ($urandom() & 32'hffff);
      status <= exp_status;
      done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  // Retries WAIT a bounded number of times, then judges the answer
  task automatic dap(input logic ap, input logic rd, input logic [1:0] a,
      input logic [31:0] wd, input logic [1:0] flt, input logic [2:0] ea,
      output logic [31:0] d);
    logic [2:0] ack;
    logic       pok;
    int         n;
    n = 0;
    do begin
      host.xfer(ap, rd, a, wd, flt, ack, d, pok);
      n++;
    end while (ack === pefc_pkg::ACK_WAIT && n < 20);
    check({29'h0, ack}, {29'h0, ea});
    if (rd && ack === pefc_pkg::ACK_OK) check({31'h0, pok}, 32'h1);
  endtask

  task automatic wr_io(input logic [31:0] ad, input logic [31:0] wd);
    logic [31:0] d;
    dap(1'b1, 1'b0, pefc_pkg::AP_TAR, ad, 2'h0, 3'h1, d);
    dap(1'b1, 1'b0, pefc_pkg::AP_DRW, wd, 2'h0, 3'h1, d);
  endtask

  task automatic rd_io(input logic [31:0] ad, output logic [31:0] d);
    dap(1'b1, 1'b0, pefc_pkg::AP_TAR, ad, 2'h0, 3'h1, d);
    dap(1'b1, 1'b1, pefc_pkg::AP_DRW, 32'h0, 2'h0, 3'h1, d);
    dap(1'b0, 1'b1, pefc_pkg::DP_RDBUFF, 32'h0, 2'h0, 3'h1, d);
  endtask

  task automatic chk_io(input logic [31:0] ad, input logic [31:0] e);
    logic [31:0] d;
    rd_io(ad, d);
    check(d, e);
  endtask

  task automatic session();
    logic [31:0] d;
    logic [31:0] v;
    logic [31:0] ad;
    int          poll;
    dap(1'b0, 1'b1, pefc_pkg::DP_ID_ABORT, 32'h0, 2'h0, 3'h7, d);
    host.line_reset();
    dap(1'b0, 1'b1, pefc_pkg::DP_ID_ABORT, 32'h0, 2'h0, 3'h1, d);
    check(d, ID);
    if (err_count > 0) return;
    dap(1'b0, 1'b1, pefc_pkg::DP_ID_ABORT, 32'h0, 2'h1, 3'h7, d);
    host.line_reset();
    for (int i = 0; i < pefc_pkg::PARAM_WORDS; i++) begin
      ad = pefc_pkg::REQUEST_PARAM_BASE + 32'(4 * i);
      mdl[ad] = $urandom();
      wr_io(ad, mdl[ad]);
    end
    for (int i = 0; i < pefc_pkg::PARAM_WORDS; i++) begin
      ad = pefc_pkg::REQUEST_PARAM_BASE + 32'(4 * i);
      @(posedge ref_clk_in);
      paddr <= 4'(i);
      repeat (2) @(posedge ref_clk_in);
      #1 check(pdata, mdl[ad]);
      chk_io(ad, mdl[ad]);
    end
    wr_io(32'h4000_0100, $urandom());
    chk_io(32'h4000_0100, 32'h0);
    wr_io(pefc_pkg::SYSTEM_ARGUMENT_ADDR, pefc_pkg::REQUEST_PARAM_BASE);
    chk_io(pefc_pkg::SYSTEM_ARGUMENT_ADDR, pefc_pkg::REQUEST_PARAM_BASE);
    dap(1'b1, 1'b0, pefc_pkg::AP_TAR, 32'h0, 2'h2, 3'h1, d);
    dap(1'b1, 1'b1, pefc_pkg::AP_CSW, 32'h0, 2'h0, 3'h4, d);
    dap(1'b0, 1'b1, pefc_pkg::DP_CTRL_STAT, 32'h0, 2'h0, 3'h1, d);
    check({31'h0, d[pefc_pkg::WDATAERR_POS]}, 32'h1);
    dap(1'b0, 1'b0, pefc_pkg::DP_ID_ABORT, 32'h8, 2'h0, 3'h1, d);
    dap(1'b1, 1'b1, pefc_pkg::AP_CSW, 32'h0, 2'h0, 3'h1, d);
    check(d, pefc_pkg::CSW_RST);
    v = $urandom();
    dap(1'b1, 1'b0, pefc_pkg::AP_CSW, v, 2'h0, 3'h1, d);
    dap(1'b1, 1'b1, pefc_pkg::AP_CSW, 32'h0, 2'h0, 3'h1, d);
    check(d, v);
    exp_req = pefc_pkg::SYSREQ_BIT | 32'($urandom_range(255));
    wr_io(pefc_pkg::SYSTEM_REQUEST_ADDR, exp_req);
    rd_io(pefc_pkg::SYSTEM_REQUEST_ADDR, d);
    check(d, exp_req | pefc_pkg::PRIVILEGED_BIT);
    v = pefc_pkg::SYSREQ_BIT | pefc_pkg::PRIVILEGED_BIT;
    poll = 0;
    while ((d & v) !== 32'h0 && poll < 40) begin
      rd_io(pefc_pkg::SYSTEM_REQUEST_ADDR, d);
      poll++;
    end
    check(d, exp_req & ~v);
    check({31'h0, priv}, 32'h0);
    chk_io(pefc_pkg::SYSTEM_ARGUMENT_ADDR, exp_status);
    check(arg & 32'hf000_0000, pefc_pkg::STATUS_SUCCEEDED);
    wr_io(pefc_pkg::PROG_ENTRY_ADDR, 32'h0);
    repeat (4) @(posedge ref_clk_in);
    check({31'h0, pmode}, 32'h0);
    wr_io(pefc_pkg::PROG_ENTRY_ADDR, pefc_pkg::PROG_MODE_BIT | 32'h5a);
    repeat (4) @(posedge ref_clk_in);
    check({31'h0, pmode}, 32'h1);
  endtask

  initial begin
    // A real edge at time 0, so the link logic resets before its clock runs
    reset_n_in <= 1'b0;
    void'($urandom(11));
    repeat (6) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    session();
    @(posedge ref_clk_in);
    reset_n_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    check({28'h0, dev_oe, priv, pmode, start}, 32'h0);
    check(req | arg, 32'h0);
    reset_n_in <= 1'b1;
    session();
    summarize();
  end

  // Two sessions need well under a third of this span
  initial begin
    repeat (40000) @(posedge ref_clk_in);
    err_count++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
